/* File: shared/timebase_params.svh */
/*
 Timing counts and reset values for the timebase and run-mode flag block.
 Assumes a 100 MHz reference clock; included by bare name.
*/
`ifndef TIMEBASE_PARAMS_SVH
`define TIMEBASE_PARAMS_SVH

`define TB_CLK_PERIOD_NS   10
`define TB_MS_NS           1000000
`define TB_MS_CYCLES       (`TB_MS_NS / `TB_CLK_PERIOD_NS)
`define TB_HALF10_MS       5
`define TB_HALF100_TICKS   10
`define TB_HALF1S_TICKS    100
`define TB_HALF1MIN_TICKS  6000
`define TB_SEC_MAX         59
`define TB_MIN_MAX         59
`define TB_HOUR_MAX        23
`define TB_ADJ_SEC         30
`define TB_RTC_PRESENT     1'b1

`endif

/* File: shared/timebase_pkg.sv */
/*
 Types shared by the timebase files.
 Assumes the params header supplies all counts.
*/
package timebase_pkg;

   typedef struct packed {
      logic p10ms;
      logic p100ms;
      logic p1s;
      logic p1min;
   } pulse_flags_t;

   typedef struct packed {
      logic [4:0] hour;
      logic [5:0] min;
      logic [5:0] sec;
   } rtc_time_t;

   typedef enum logic [1:0] {
      SCAN_IDLE = 2'b00,
      SCAN_RUN  = 2'b01,
      SCAN_WAIT = 2'b11
   } scan_state_t;

endpackage

/* File: core/pulse_timebase.sv */
/*
 Common timebase: millisecond tick and the four square-wave flags.
 Assumes a synchronous active-low reset and one clock.
*/
`timescale 1ns/1ps
`include "timebase_params.svh"

module pulse_timebase #(
   parameter int MS_CYCLES = `TB_MS_CYCLES
) (
   // Clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    rstn,
   // Ticks and flags
   output logic                         msTick,
   output logic                         secTick,
   output timebase_pkg::pulse_flags_t   flags
);

   logic [31:0]               cycCnt_r,  cycCnt_nxt;
   logic [2:0]                msCnt_r,   msCnt_nxt;
   logic [3:0]                u10_r,     u10_nxt;
   logic [6:0]                u100_r,    u100_nxt;
   logic [12:0]               u6000_r,   u6000_nxt;
   logic                      msTick_nxt, secTick_nxt;
   timebase_pkg::pulse_flags_t flags_nxt;

   always_comb begin
      logic t5;
      t5          = 1'b0;
      cycCnt_nxt  = cycCnt_r + 32'h0000_0001;
      msTick_nxt  = 1'b0;
      secTick_nxt = 1'b0;
      msCnt_nxt   = msCnt_r;
      u10_nxt     = u10_r;
      u100_nxt    = u100_r;
      u6000_nxt   = u6000_r;
      flags_nxt   = flags;
      if (cycCnt_r == 32'(MS_CYCLES - 1)) begin
         cycCnt_nxt = 32'h0000_0000;
         msTick_nxt = 1'b1;
         msCnt_nxt  = msCnt_r + 3'h1;
         if (msCnt_r == 3'(`TB_HALF10_MS - 1)) begin
            msCnt_nxt = 3'h0;
            t5        = 1'b1;
         end
      end
      // One 5 ms step drives every flag
      if (t5) begin
         flags_nxt.p10ms = ~flags.p10ms;
         u10_nxt   = u10_r + 4'h1;
         u100_nxt  = u100_r + 7'h01;
         u6000_nxt = u6000_r + 13'h0001;
         if (u10_r == 4'(`TB_HALF100_TICKS - 1)) begin
            u10_nxt          = 4'h0;
            flags_nxt.p100ms = ~flags.p100ms;
         end
         if (u100_r == 7'(`TB_HALF1S_TICKS - 1)) begin
            u100_nxt      = 7'h00;
            flags_nxt.p1s = ~flags.p1s;
            secTick_nxt   = flags.p1s;
         end
         if (u6000_r == 13'(`TB_HALF1MIN_TICKS - 1)) begin
            u6000_nxt       = 13'h0000;
            flags_nxt.p1min = ~flags.p1min;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cycCnt_r <= 32'h0000_0000;
         msCnt_r  <= 3'h0;
         u10_r    <= 4'h0;
         u100_r   <= 7'h00;
         u6000_r  <= 13'h0000;
         msTick   <= 1'b0;
         secTick  <= 1'b0;
         flags    <= '0;
      end else begin
         cycCnt_r <= cycCnt_nxt;
         msCnt_r  <= msCnt_nxt;
         u10_r    <= u10_nxt;
         u100_r   <= u100_nxt;
         u6000_r  <= u6000_nxt;
         msTick   <= msTick_nxt;
         secTick  <= secTick_nxt;
         flags    <= flags_nxt;
      end
   end

endmodule

/* File: core/timebase_mode_flags.sv */
/*
 Timebase pulse flags, real-time-clock flags and run-mode control flags.
 Assumes software drives the control flags and the scan engine reports scan end.
*/
`timescale 1ns/1ps
`include "timebase_params.svh"

module timebase_mode_flags #(
   parameter int MS_CYCLES = `TB_MS_CYCLES,
   parameter int OUT_W     = 16
) (
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rstn,
   // Pulse flags
   output logic                        pulse_10ms_flag,
   output logic                        pulse_100ms_flag,
   output logic                        pulse_1s_flag,
   output logic                        pulse_1min_flag,
   // Real-time clock
   input  wire logic                   rtc_stop_preset,
   input  wire logic                   rtc_display_freeze,
   input  wire logic                   rtc_thirty_sec_adjust,
   input  wire timebase_pkg::rtc_time_t rtcPresetValue,
   output timebase_pkg::rtc_time_t     rtcReadout,
   output logic                        rtc_present_flag,
   output logic                        rtc_fault_flag,
   // Run mode and memory
   input  wire logic                   runMode,
   input  wire logic                   hold_on_stop,
   input  wire logic                   nonretained_clear_req,
   input  wire logic                   retained_clear_req,
   output logic                        imageClear,
   output logic                        valueClear,
   output logic                        retainedClear,
   // Outputs
   input  wire logic                   outputs_off_force,
   input  wire logic [OUT_W-1:0]       outImage,
   output logic [OUT_W-1:0]            extOutputs,
   // Scan pacing
   input  wire logic                   fixed_cycle_mode,
   input  wire logic [15:0]            fixed_cycle_period,
   input  wire logic                   scanDone,
   output logic                        scanStart
);

   logic                       msTick, secTick;
   timebase_pkg::pulse_flags_t flags;

   pulse_timebase #(.MS_CYCLES(MS_CYCLES)) pulse_timebase_inst (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .msTick  (msTick),
      .secTick (secTick),
      .flags   (flags)
   );

   assign pulse_10ms_flag  = flags.p10ms;
   assign pulse_100ms_flag = flags.p100ms;
   assign pulse_1s_flag    = flags.p1s;
   assign pulse_1min_flag  = flags.p1min;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Real-time clock

   function automatic timebase_pkg::rtc_time_t nextMinute(timebase_pkg::rtc_time_t t);
      timebase_pkg::rtc_time_t r;
      r     = t;
      r.sec = 6'h00;
      if (t.min >= 6'(`TB_MIN_MAX)) begin
         r.min  = 6'h00;
         r.hour = (t.hour >= 5'(`TB_HOUR_MAX)) ? 5'h00 : t.hour + 5'h01;
      end else begin
         r.min = t.min + 6'h01;
      end
      return r;
   endfunction

   function automatic logic timeBad(timebase_pkg::rtc_time_t t);
      return (t.sec > 6'(`TB_SEC_MAX)) || (t.min > 6'(`TB_MIN_MAX)) ||
             (t.hour > 5'(`TB_HOUR_MAX));
   endfunction

   timebase_pkg::rtc_time_t rtcTime_r, rtcTime_nxt, rtcReadout_nxt;
   logic                    adjPrev_r, fault_nxt;

   always_comb begin
      rtcTime_nxt = rtcTime_r;
      if (rtc_stop_preset) begin
         rtcTime_nxt = rtcPresetValue;
      end else if (rtc_thirty_sec_adjust && !adjPrev_r) begin
         if (rtcTime_r.sec >= 6'(`TB_ADJ_SEC)) begin
            rtcTime_nxt = nextMinute(rtcTime_r);
         end else begin
            rtcTime_nxt.sec = 6'h00;
         end
      end else if (secTick && !timeBad(rtcTime_r)) begin
         if (rtcTime_r.sec >= 6'(`TB_SEC_MAX)) begin
            rtcTime_nxt = nextMinute(rtcTime_r);
         end else begin
            rtcTime_nxt.sec = rtcTime_r.sec + 6'h01;
         end
      end
      rtcReadout_nxt = rtc_display_freeze ? rtcReadout : rtcTime_r;
      fault_nxt      = timeBad(rtcTime_r);
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rtcTime_r        <= '0;
         rtcReadout       <= '0;
         adjPrev_r        <= 1'b0;
         rtc_fault_flag   <= 1'b0;
         rtc_present_flag <= `TB_RTC_PRESENT;
      end else begin
         rtcTime_r        <= rtcTime_nxt;
         rtcReadout       <= rtcReadout_nxt;
         adjPrev_r        <= rtc_thirty_sec_adjust;
         rtc_fault_flag   <= fault_nxt;
         rtc_present_flag <= `TB_RTC_PRESENT;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Memory clear and outputs

   logic             runPrev_r, nrPrev_r, rPrev_r;
   logic             imageClear_nxt, valueClear_nxt, retainedClear_nxt;
   logic [OUT_W-1:0] extOutputs_nxt;

   always_comb begin
      logic runFall, nrRise;
      runFall           = runPrev_r && !runMode;
      nrRise            = nonretained_clear_req && !nrPrev_r;
      imageClear_nxt    = nrRise || (runFall && !hold_on_stop);
      valueClear_nxt    = nrRise || (runFall && !hold_on_stop);
      retainedClear_nxt = retained_clear_req && !rPrev_r;
      extOutputs_nxt    = outputs_off_force ? '0 : outImage;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         runPrev_r     <= 1'b0;
         nrPrev_r      <= 1'b0;
         rPrev_r       <= 1'b0;
         imageClear    <= 1'b0;
         valueClear    <= 1'b0;
         retainedClear <= 1'b0;
         extOutputs    <= '0;
      end else begin
         runPrev_r     <= runMode;
         nrPrev_r      <= nonretained_clear_req;
         rPrev_r       <= retained_clear_req;
         imageClear    <= imageClear_nxt;
         valueClear    <= valueClear_nxt;
         retainedClear <= retainedClear_nxt;
         extOutputs    <= extOutputs_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Scan pacing

   timebase_pkg::scan_state_t state_r, state_nxt;
   logic [15:0]               elapsed_r, elapsed_nxt;
   logic                      scanStart_nxt;

   always_comb begin
      state_nxt     = state_r;
      scanStart_nxt = 1'b0;
      elapsed_nxt   = (msTick && elapsed_r != 16'hFFFF) ? elapsed_r + 16'h0001 : elapsed_r;
      unique case (state_r)
         timebase_pkg::SCAN_IDLE: begin
            if (runMode) begin
               state_nxt     = timebase_pkg::SCAN_RUN;
               scanStart_nxt = 1'b1;
               elapsed_nxt   = 16'h0000;
            end
         end
         timebase_pkg::SCAN_RUN: begin
            if (scanDone) begin
               if (!runMode) begin
                  state_nxt = timebase_pkg::SCAN_IDLE;
               end else if (fixed_cycle_mode && elapsed_nxt < fixed_cycle_period) begin
                  state_nxt = timebase_pkg::SCAN_WAIT;
               end else begin
                  scanStart_nxt = 1'b1;
                  elapsed_nxt   = 16'h0000;
               end
            end
         end
         timebase_pkg::SCAN_WAIT: begin
            if (!runMode) begin
               state_nxt = timebase_pkg::SCAN_IDLE;
            end else if (!fixed_cycle_mode || elapsed_nxt >= fixed_cycle_period) begin
               state_nxt     = timebase_pkg::SCAN_RUN;
               scanStart_nxt = 1'b1;
               elapsed_nxt   = 16'h0000;
            end
         end
         default: state_nxt = timebase_pkg::SCAN_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_r   <= timebase_pkg::SCAN_IDLE;
         elapsed_r <= 16'h0000;
         scanStart <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         elapsed_r <= elapsed_nxt;
         scanStart <= scanStart_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   sequence s_fixedWait;
      state_r == timebase_pkg::SCAN_WAIT && runMode && fixed_cycle_mode;
   endsequence

   a_pulse10_tick:    assert property ($changed(pulse_10ms_flag) |-> msTick)
      else $error("10 ms flag moved off a millisecond tick");
   a_pulse100_align:  assert property ($changed(pulse_100ms_flag) |->
                         $changed(pulse_10ms_flag))
      else $error("100 ms flag edge not aligned to 10 ms flag");
   a_pulse1s_align:   assert property ($changed(pulse_1s_flag) |->
                         $changed(pulse_100ms_flag))
      else $error("1 s flag edge not aligned to 100 ms flag");
   a_pulse1min_align: assert property ($changed(pulse_1min_flag) |->
                         $changed(pulse_1s_flag))
      else $error("1 min flag edge not aligned to 1 s flag");
   a_rtc_preset:      assert property (rtc_stop_preset |=>
                         rtcTime_r == $past(rtcPresetValue))
      else $error("stopped clock did not take the preset");
   a_rtc_freeze:      assert property (rtc_display_freeze |=> $stable(rtcReadout))
      else $error("readout moved while frozen");
   a_rtc_present:     assert property ($past(rstn) |-> rtc_present_flag)
      else $error("presence flag low");
   a_rtc_fault:       assert property (timeBad(rtcTime_r) |=> rtc_fault_flag)
      else $error("bad time not flagged");
   a_hold_stop:       assert property ($fell(runMode) && hold_on_stop |=> !imageClear)
      else $error("memory cleared despite hold");
   a_outputs_off:     assert property (outputs_off_force |=> extOutputs == '0)
      else $error("outputs on while forced off");
   a_clear_req:       assert property ($rose(nonretained_clear_req) |=>
                         imageClear && valueClear)
      else $error("clear request not honoured");
   a_fixed_wait:      assert property (s_fixedWait and (elapsed_r + 16'h0001 < fixed_cycle_period)
                                       |=> !scanStart)
      else $error("scan started before its period");
   a_flags_reset:     assert property ($rose(rstn) |-> flags == '0)
      else $error("pulse flags not low after reset");

endmodule

/* File: tb/timebase_mode_flags_bench.sv */
/*
 Self-checking bench for the timebase and run-mode flag block.
 Assumes the params header and the package are compiled before it.
*/
`timescale 1ns/1ps

module timebase_mode_flags_bench;
   localparam int MS    = 2;
   localparam int LIMIT = 90000;

   logic                    ref_clk;
   logic                    rstn;
   logic                    p10;
   logic                    p100;
   logic                    p1s;
   logic                    p1min;
   logic                    stopPre;
   logic                    freeze;
   logic                    adj30;
   logic                    present;
   logic                    fault;
   timebase_pkg::rtc_time_t presetVal;
   timebase_pkg::rtc_time_t readout;
   logic                    runMode;
   logic                    hold;
   logic                    clrN;
   logic                    clrR;
   logic                    imgClr;
   logic                    valClr;
   logic                    retClr;
   logic                    offForce;
   logic [15:0]             outImage;
   logic [15:0]             extOut;
   logic                    fixMode;
   logic [15:0]             period;
   logic                    scanDone;
   logic                    scanStart;
   int                      n_mismatch;
   int                      cmp_count;
   int                      cyc;
   int                      relCyc;
   int                      hc [4];
   wire logic [3:0]         fl = {p1min, p1s, p100, p10};
   wire logic [3:0]         pv = {retClr, valClr, imgClr, scanStart};

   timebase_mode_flags #(.MS_CYCLES(MS), .OUT_W(16)) timebase_mode_flags_inst (
      .ref_clk(ref_clk), .rstn(rstn),
      .pulse_10ms_flag(p10), .pulse_100ms_flag(p100),
      .pulse_1s_flag(p1s), .pulse_1min_flag(p1min),
      .rtc_stop_preset(stopPre), .rtc_display_freeze(freeze),
      .rtc_thirty_sec_adjust(adj30), .rtcPresetValue(presetVal),
      .rtcReadout(readout), .rtc_present_flag(present), .rtc_fault_flag(fault),
      .runMode(runMode), .hold_on_stop(hold),
      .nonretained_clear_req(clrN), .retained_clear_req(clrR),
      .imageClear(imgClr), .valueClear(valClr), .retainedClear(retClr),
      .outputs_off_force(offForce), .outImage(outImage), .extOutputs(extOut),
      .fixed_cycle_mode(fixMode), .fixed_cycle_period(period),
      .scanDone(scanDone), .scanStart(scanStart));

   ////////////////////////////////////////////////////////////////////////
   // Clock, timeout, reporting
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Helpers
   task automatic wait_edge(input int i, output int n);
      logic [3:0] pr;
      pr = fl;
      n  = 0;
      while (fl[i] === pr[i] && n < 70000) begin
         pr = fl;
         @(negedge ref_clk);
         n++;
      end
      chk(fl[0] ^ pr[0], 1);
   endtask

   task automatic hits();
      for (int k = 0; k < 4; k++) hc[k] = 0;
      repeat (6) begin
         @(negedge ref_clk);
         for (int k = 0; k < 4; k++) if (pv[k] === 1'b1) hc[k]++;
      end
   endtask

   task automatic wait_start(output int n);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (scanStart !== 1'b1 && n < 200);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      @(negedge ref_clk);
      chk(fl, 4'h0);
      chk(present, 1'b1);
   endtask

   task automatic t_pulse(input int i, input int half);
      int n;
      wait_edge(i, n);
      repeat (2) begin
         wait_edge(i, n);
         chk(n, half);
      end
   endtask

   task automatic t_outputs();
      @(posedge ref_clk);
      outImage <= 16'hA5C3;
      repeat (3) @(negedge ref_clk);
      chk(extOut, 16'hA5C3);
      @(posedge ref_clk);
      offForce <= 1'b1;
      repeat (3) @(negedge ref_clk);
      chk(extOut, 16'h0000);
      @(posedge ref_clk);
      offForce <= 1'b0;
   endtask

   task automatic t_rtc();
      @(posedge ref_clk);
      stopPre   <= 1'b1;
      presetVal <= {5'h17, 6'h3B, 6'h3A};
      repeat (4) @(negedge ref_clk);
      chk(readout, {5'h17, 6'h3B, 6'h3A});
      chk(fault, 1'b0);
      @(posedge ref_clk);
      freeze    <= 1'b1;
      presetVal <= {5'h01, 6'h02, 6'h03};
      repeat (4) @(negedge ref_clk);
      chk(readout, {5'h17, 6'h3B, 6'h3A});
      @(posedge ref_clk);
      freeze <= 1'b0;
      repeat (4) @(negedge ref_clk);
      chk(readout, {5'h01, 6'h02, 6'h03});
      @(posedge ref_clk);
      presetVal <= {5'h18, 6'h02, 6'h03};
      repeat (4) @(negedge ref_clk);
      chk(fault, 1'b1);
      @(posedge ref_clk);
      presetVal <= {5'h01, 6'h02, 6'h28};
      @(posedge ref_clk);
      stopPre <= 1'b0;
      @(posedge ref_clk);
      adj30 <= 1'b1;
      repeat (4) @(negedge ref_clk);
      chk(readout, {5'h01, 6'h03, 6'h00});
      chk(fault, 1'b0);
      @(posedge ref_clk);
      adj30 <= 1'b0;
   endtask

   task automatic t_scan();
      int n;
      @(posedge ref_clk);
      fixMode <= 1'b1;
      period  <= 16'h000A;
      runMode <= 1'b1;
      wait_start(n);
      chk(n < 200, 1);
      @(posedge ref_clk);
      scanDone <= 1'b1;
      @(posedge ref_clk);
      scanDone <= 1'b0;
      wait_start(n);
      chk(n >= 6 * MS && n <= 12 * MS, 1);
      @(posedge ref_clk);
      fixMode  <= 1'b0;
      scanDone <= 1'b1;
      @(posedge ref_clk);
      scanDone <= 1'b0;
      wait_start(n);
      chk(n <= 3, 1);
   endtask

   task automatic t_clear();
      @(posedge ref_clk);
      clrN <= 1'b1;
      hits();
      chk(hc[1], 1);
      chk(hc[2], 1);
      chk(hc[3], 0);
      @(posedge ref_clk);
      clrN <= 1'b0;
      clrR <= 1'b1;
      hits();
      chk(hc[3], 1);
      @(posedge ref_clk);
      clrR <= 1'b0;
      hold <= 1'b1;
      @(posedge ref_clk);
      runMode <= 1'b0;
      hits();
      chk(hc[1] + hc[2], 0);
      @(posedge ref_clk);
      hold    <= 1'b0;
      runMode <= 1'b1;
      repeat (3) @(posedge ref_clk);
      runMode <= 1'b0;
      hits();
      chk(hc[1], 1);
   endtask

   task automatic t_minute();
      int n;
      wait_edge(3, n);
      chk(p1min, 1'b1);
      chk((cyc - relCyc) >= 30000 * MS - 3 && (cyc - relCyc) <= 30000 * MS + 3, 1);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      n_mismatch = 0;
      cmp_count  = 0;
      cyc        = 0;
      rstn       = 1'b0;
      stopPre    = 1'b0;
      freeze     = 1'b0;
      adj30      = 1'b0;
      presetVal  = '0;
      runMode    = 1'b0;
      hold       = 1'b0;
      clrN       = 1'b0;
      clrR       = 1'b0;
      offForce   = 1'b0;
      outImage   = 16'h0000;
      fixMode    = 1'b0;
      period     = 16'h0000;
      scanDone   = 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn   <= 1'b1;
      relCyc = cyc;
      t_reset();
      t_pulse(0, 5 * MS);
      t_pulse(1, 50 * MS);
      t_pulse(2, 500 * MS);
      t_outputs();
      t_rtc();
      t_scan();
      t_clear();
      t_minute();
      test_done();
   end
endmodule
